// >>> rtl/psda_stall.sv
`timescale 1ns/1ps
`default_nettype none

module psda_stall
    import psda_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // Load
    input  wire logic       i_load,
    input  wire logic [1:0] i_count,
    // Stall
    output logic            o_busy
);

    logic [1:0] count_r;
    logic [1:0] count_nxt;
    logic       busy_r;
    logic       busy_nxt;

    always_comb begin
        count_nxt = count_r;
        if (i_load) begin
            count_nxt = i_count;
        end else if (count_r != XTRA_NONE) begin
            count_nxt = count_r - XTRA_ONE;
        end
        busy_nxt = (count_nxt != XTRA_NONE);
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_r <= XTRA_NONE;
            busy_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            busy_r  <= busy_nxt;
        end
    end

    assign o_busy = busy_r;

endmodule : psda_stall

`default_nettype wire

// >>> rtl/psda_top.sv
`timescale 1ns/1ps
`default_nettype none

module psda_top
    import psda_pkg::*;
(
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_nrst,
    // Wishbone slave
    input  wire logic               i_wb_cyc,
    input  wire logic               i_wb_stb,
    input  wire logic               i_wb_we,
    input  wire logic [WBA_W-1:0]   i_wb_adr,
    input  wire logic [3:0]         i_wb_sel,
    input  wire logic [WBD_W-1:0]   i_wb_dat,
    output logic      [WBD_W-1:0]   o_wb_dat,
    output logic                    o_wb_ack,
    // Core request
    input  wire logic               i_req_valid,
    input  wire logic [1:0]         i_req_kind,
    input  wire logic               i_req_write,
    input  wire logic               i_req_byte,
    input  wire logic               i_req_high,
    input  wire logic [PC_W-1:0]    i_pc,
    input  wire logic [EA_W-1:0]    i_ea,
    input  wire logic [DW-1:0]      i_wdata,
    input  wire logic               i_tbl_busy,
    // MAC operand selection
    input  wire logic               i_mac_op,
    input  wire logic               i_y_pointer,
    // Instruction timing context
    input  wire logic               i_short_class,
    input  wire logic               i_in_repeat,
    input  wire logic               i_rpt_edge,
    // Program memory
    output logic      [PADDR_W-1:0] o_prog_addr,
    output logic                    o_prog_rd,
    output logic                    o_prog_wr,
    output logic                    o_prog_wr_high,
    output logic      [DW-1:0]      o_prog_wdata,
    input  wire logic [PW-1:0]      i_prog_rdata,
    // Data RAM
    output logic      [EA_W-1:0]    o_ram_addr,
    output logic                    o_ram_rd,
    output logic                    o_ram_wr,
    output logic                    o_ram_byte,
    output logic      [DW-1:0]      o_ram_wdata,
    input  wire logic [DW-1:0]      i_ram_rdata,
    // Result to core
    output logic      [DW-1:0]      o_rdata,
    output logic                    o_rvalid,
    output logic                    o_stall
);

    // Pick one byte of a word, or pass the word
    function automatic logic [DW-1:0] pick_byte(
        input logic [DW-1:0] w,
        input logic          is_byte,
        input logic          bsel
    );
        logic [DW-1:0] r;
        r = w;
        if (is_byte) begin
            r = {ZERO_BYTE, (bsel ? w[15:8] : w[7:0])};
        end
        return r;
    endfunction : pick_byte

    function automatic logic in_y(input logic [EA_W-1:0] ea);
        return (ea >= Y_LO) && (ea <= Y_HI);
    endfunction : in_y

    logic              vis_en;
    logic [PAGE_W-1:0] tbl_page;
    logic [PAGE_W-1:0] vis_page;
    logic              stall_busy;

    psda_wb_regs u_regs (
        .i_clk      (i_clk),
        .i_nrst     (i_nrst),
        .i_wb_cyc   (i_wb_cyc),
        .i_wb_stb   (i_wb_stb),
        .i_wb_we    (i_wb_we),
        .i_wb_adr   (i_wb_adr),
        .i_wb_sel   (i_wb_sel),
        .i_wb_dat   (i_wb_dat),
        .o_wb_dat   (o_wb_dat),
        .o_wb_ack   (o_wb_ack),
        .i_last_adr (o_prog_addr),
        .o_vis_en   (vis_en),
        .o_tbl_page (tbl_page),
        .o_vis_page (vis_page)
    );

    // Request decode
    psda_kind_t        kind;
    logic              win_hit;
    logic              ram_ok;
    logic [1:0]        xtra;
    logic              load_stall;

    always_comb begin
        kind    = psda_kind_t'(i_req_kind);
        // EA MSB marks the whole 0x8000+ half as window candidate
        win_hit = (kind == KIND_DATA) && i_ea[EA_WIN_BIT]
                  && vis_en
                  && !i_tbl_busy;
        ram_ok  = (i_ea <= RAM_TOP);
        if (i_mac_op && !i_req_write) begin
            // Y pointers see only Y; X pointers see all but Y
            ram_ok = ram_ok && (i_y_pointer == in_y(i_ea));
        end
        if (!i_in_repeat) begin
            xtra = i_short_class ? XTRA_ONE : XTRA_TWO;
        end else begin
            xtra = i_rpt_edge ? XTRA_TWO : XTRA_ONE;
        end
        load_stall = i_req_valid && win_hit && !i_req_write;
    end

    psda_stall u_stall (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_load  (load_stall),
        .i_count (xtra),
        .o_busy  (stall_busy)
    );

    // Stage 1: addresses to the arrays
    logic [PADDR_W-1:0] paddr_r, paddr_nxt;
    logic               prd_r, prd_nxt;
    logic               pwr_r, pwr_nxt;
    logic               pwh_r, pwh_nxt;
    logic [DW-1:0]      pwd_r, pwd_nxt;
    logic [EA_W-1:0]    raddr_r, raddr_nxt;
    logic               rrd_r, rrd_nxt;
    logic               rwr_r, rwr_nxt;
    logic               rby_r, rby_nxt;
    logic [DW-1:0]      rwd_r, rwd_nxt;
    logic               s1v_r, s1v_nxt;
    psda_src_t          s1src_r, s1src_nxt;
    logic               s1by_r, s1by_nxt;
    logic               s1bs_r, s1bs_nxt;

    always_comb begin
        paddr_nxt = paddr_r;
        prd_nxt   = 1'b0;
        pwr_nxt   = 1'b0;
        pwh_nxt   = pwh_r;
        pwd_nxt   = pwd_r;
        raddr_nxt = raddr_r;
        rrd_nxt   = 1'b0;
        rwr_nxt   = 1'b0;
        rby_nxt   = rby_r;
        rwd_nxt   = rwd_r;
        s1v_nxt   = 1'b0;
        s1src_nxt = s1src_r;
        s1by_nxt  = i_req_byte;
        s1bs_nxt  = i_ea[0];
        if (i_req_valid) begin
            unique case (kind)
                KIND_FETCH: begin
                    // Fetch steps by two and never sets bit 23
                    paddr_nxt = {1'b0, i_pc[PC_W-1:1], 1'b0};
                    prd_nxt   = 1'b1;
                end
                KIND_TABLE: begin
                    // Page top bit chooses configuration space
                    paddr_nxt = {tbl_page, i_ea};
                    prd_nxt   = !i_req_write;
                    pwr_nxt   = i_req_write;
                    pwh_nxt   = i_req_high;
                    pwd_nxt   = i_wdata;
                    s1v_nxt   = !i_req_write;
                    s1src_nxt = i_req_high ? SRC_PHI : SRC_PLO;
                end
                KIND_DATA: begin
                    if (win_hit) begin
                        paddr_nxt = {1'b0, vis_page,
                                     i_ea[EA_WIN_BIT-1:0]};
                        // Program space is read-only through the window
                        prd_nxt   = !i_req_write;
                        s1src_nxt = SRC_PLO;
                    end else if (ram_ok) begin
                        raddr_nxt = i_ea;
                        rrd_nxt   = !i_req_write;
                        rwr_nxt   = i_req_write;
                        rby_nxt   = i_req_byte;
                        rwd_nxt   = i_wdata;
                        s1src_nxt = SRC_RAM;
                    end else begin
                        s1src_nxt = SRC_ZERO;
                    end
                    s1v_nxt = !i_req_write;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            paddr_r <= '0;
            prd_r   <= 1'b0;
            pwr_r   <= 1'b0;
            pwh_r   <= 1'b0;
            pwd_r   <= '0;
            raddr_r <= '0;
            rrd_r   <= 1'b0;
            rwr_r   <= 1'b0;
            rby_r   <= 1'b0;
            rwd_r   <= '0;
            s1v_r   <= 1'b0;
            s1src_r <= SRC_ZERO;
            s1by_r  <= 1'b0;
            s1bs_r  <= 1'b0;
        end else begin
            paddr_r <= paddr_nxt;
            prd_r   <= prd_nxt;
            pwr_r   <= pwr_nxt;
            pwh_r   <= pwh_nxt;
            pwd_r   <= pwd_nxt;
            raddr_r <= raddr_nxt;
            rrd_r   <= rrd_nxt;
            rwr_r   <= rwr_nxt;
            rby_r   <= rby_nxt;
            rwd_r   <= rwd_nxt;
            s1v_r   <= s1v_nxt;
            s1src_r <= s1src_nxt;
            s1by_r  <= s1by_nxt;
            s1bs_r  <= s1bs_nxt;
        end
    end

    // Stage 2: format the returned data
    logic [DW-1:0] rdata_r, rdata_nxt;
    logic          rvalid_r, rvalid_nxt;
    logic [DW-1:0] hi_word;

    always_comb begin
        // Upper byte of the high lane is always zero
        hi_word    = {ZERO_BYTE, i_prog_rdata[PW-1:DW]};
        rvalid_nxt = s1v_r;
        rdata_nxt  = rdata_r;
        if (s1v_r) begin
            unique case (s1src_r)
                SRC_ZERO: rdata_nxt = ZERO_WORD;
                SRC_PLO:  rdata_nxt = pick_byte(i_prog_rdata[DW-1:0],
                                                s1by_r, s1bs_r);
                SRC_PHI:  rdata_nxt = pick_byte(hi_word,
                                                s1by_r, s1bs_r);
                SRC_RAM:  rdata_nxt = pick_byte(i_ram_rdata,
                                                s1by_r, s1bs_r);
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_r  <= ZERO_WORD;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign o_prog_addr    = paddr_r;
    assign o_prog_rd      = prd_r;
    assign o_prog_wr      = pwr_r;
    assign o_prog_wr_high = pwh_r;
    assign o_prog_wdata   = pwd_r;
    assign o_ram_addr     = raddr_r;
    assign o_ram_rd       = rrd_r;
    assign o_ram_wr       = rwr_r;
    assign o_ram_byte     = rby_r;
    assign o_ram_wdata    = rwd_r;
    assign o_rdata        = rdata_r;
    assign o_rvalid       = rvalid_r;
    assign o_stall        = stall_busy;

endmodule : psda_top

`default_nettype wire

// >>> rtl/psda_wb_regs.sv
`timescale 1ns/1ps
`default_nettype none

module psda_wb_regs
    import psda_pkg::*;
(
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_nrst,
    // Wishbone slave
    input  wire logic               i_wb_cyc,
    input  wire logic               i_wb_stb,
    input  wire logic               i_wb_we,
    input  wire logic [WBA_W-1:0]   i_wb_adr,
    input  wire logic [3:0]         i_wb_sel,
    input  wire logic [WBD_W-1:0]   i_wb_dat,
    output logic      [WBD_W-1:0]   o_wb_dat,
    output logic                    o_wb_ack,
    // Block side
    input  wire logic [PADDR_W-1:0] i_last_adr,
    output logic                    o_vis_en,
    output logic      [PAGE_W-1:0]  o_tbl_page,
    output logic      [PAGE_W-1:0]  o_vis_page
);

    logic              ack_r, ack_nxt;
    logic [WBD_W-1:0]  dat_r, dat_nxt;
    logic              vis_en_r, vis_en_nxt;
    logic [PAGE_W-1:0] tbl_r, tbl_nxt;
    logic [PAGE_W-1:0] vpg_r, vpg_nxt;
    logic              hit;

    always_comb begin
        hit        = i_wb_cyc && i_wb_stb && !ack_r;
        ack_nxt    = hit;
        dat_nxt    = '0;
        vis_en_nxt = vis_en_r;
        tbl_nxt    = tbl_r;
        vpg_nxt    = vpg_r;
        if (hit && i_wb_we && i_wb_sel[0]) begin
            unique case (i_wb_adr)
                OFS_CORE_CTL: vis_en_nxt = i_wb_dat[CTL_VIS_EN_BIT];
                OFS_TBL_PAGE: tbl_nxt = i_wb_dat[PAGE_W-1:0];
                OFS_VIS_PAGE: vpg_nxt = i_wb_dat[PAGE_W-1:0];
                default: ;
            endcase
        end
        if (hit && !i_wb_we) begin
            unique case (i_wb_adr)
                OFS_CORE_CTL: dat_nxt[CTL_VIS_EN_BIT] = vis_en_r;
                OFS_TBL_PAGE: dat_nxt[PAGE_W-1:0] = tbl_r;
                OFS_VIS_PAGE: dat_nxt[PAGE_W-1:0] = vpg_r;
                OFS_LAST_ADR: dat_nxt[PADDR_W-1:0] = i_last_adr;
                default: dat_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_r    <= 1'b0;
            dat_r    <= '0;
            vis_en_r <= 1'b0;
            tbl_r    <= PAGE_RST;
            vpg_r    <= PAGE_RST;
        end else begin
            ack_r    <= ack_nxt;
            dat_r    <= dat_nxt;
            vis_en_r <= vis_en_nxt;
            tbl_r    <= tbl_nxt;
            vpg_r    <= vpg_nxt;
        end
    end

    assign o_wb_ack   = ack_r;
    assign o_wb_dat   = dat_r;
    assign o_vis_en   = vis_en_r;
    assign o_tbl_page = tbl_r;
    assign o_vis_page = vpg_r;

endmodule : psda_wb_regs

`default_nettype wire

// >>> shared/psda_pkg.sv
package psda_pkg;

    // Address and data widths
    localparam int PADDR_W = 24;
    localparam int PC_W    = 23;
    localparam int EA_W    = 16;
    localparam int DW      = 16;
    localparam int PW      = 24;
    localparam int PAGE_W  = 8;
    localparam int WBA_W   = 5;
    localparam int WBD_W   = 32;

    // Register word offsets (byte addresses)
    localparam logic [WBA_W-1:0] OFS_CORE_CTL = 5'h00;
    localparam logic [WBA_W-1:0] OFS_TBL_PAGE = 5'h04;
    localparam logic [WBA_W-1:0] OFS_VIS_PAGE = 5'h08;
    localparam logic [WBA_W-1:0] OFS_LAST_ADR = 5'h0C;

    // Field positions and reset values
    localparam int CTL_VIS_EN_BIT = 0;
    localparam int PAGE_CFG_BIT   = 7;
    localparam int EA_WIN_BIT     = 15;
    localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;

    // Data space map
    localparam logic [EA_W-1:0] Y_LO       = 16'h0900;
    localparam logic [EA_W-1:0] Y_HI       = 16'h09FF;
    localparam logic [EA_W-1:0] RAM_TOP    = 16'h09FF;
    localparam logic [EA_W-1:0] WIN_BASE   = 16'h8000;
    localparam logic [DW-1:0]   ZERO_WORD  = 16'h0000;
    localparam logic [7:0]      ZERO_BYTE  = 8'h00;

    // Extra instruction cycles for a window access
    localparam logic [1:0] XTRA_ONE = 2'h1;
    localparam logic [1:0] XTRA_TWO = 2'h2;
    localparam logic [1:0] XTRA_NONE = 2'h0;

    typedef enum logic [1:0] {
        KIND_FETCH = 2'b00,
        KIND_TABLE = 2'b01,
        KIND_DATA  = 2'b10
    } psda_kind_t;

    typedef enum logic [1:0] {
        SRC_ZERO = 2'b00,
        SRC_PLO  = 2'b01,
        SRC_PHI  = 2'b10,
        SRC_RAM  = 2'b11
    } psda_src_t;

endpackage : psda_pkg

// >>> test/psda_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module psda_asserts (
    // Clock, reset, bus
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        o_wb_ack,
    // Core request
    input wire logic        i_req_valid,
    input wire logic [1:0]  i_req_kind,
    input wire logic        i_req_write,
    input wire logic        i_req_byte,
    input wire logic        i_req_high,
    input wire logic [22:0] i_pc,
    input wire logic [15:0] i_ea,
    input wire logic        i_tbl_busy,
    input wire logic        i_mac_op,
    input wire logic        i_y_pointer,
    // Arrays and result
    input wire logic [23:0] o_prog_addr,
    input wire logic        o_prog_rd,
    input wire logic [23:0] i_prog_rdata,
    input wire logic        o_ram_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        o_rvalid
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    logic rd_req;
    logic dat_rd;
    assign rd_req = i_req_valid && !i_req_write;
    assign dat_rd = rd_req && i_req_kind == 2'b10;

    a_wb_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus ack not one cycle after request");
    a_fetch_addr: assert property (i_req_valid && i_req_kind == 2'b00 |=> o_prog_rd
        && o_prog_addr == {1'b0, $past(i_pc[22:1]), 1'b0}) else $error("fetch address wrong");
    a_tbl_addr_low: assert property (i_req_valid && i_req_kind == 2'b01
        |=> o_prog_addr[15:0] == $past(i_ea)) else $error("table address wrong");
    a_tbl_high_word: assert property (rd_req && i_req_kind == 2'b01 && i_req_high
        && !i_req_byte ##1 o_prog_rd |=> o_rvalid && o_rdata == {8'h00, $past(i_prog_rdata[23:16])})
        else $error("high table word wrong");
    a_tbl_high_b1: assert property (rd_req && i_req_kind == 2'b01 && i_req_high
        && i_req_byte && i_ea[0] |-> ##2 o_rvalid && o_rdata == 16'h0000)
        else $error("high table byte one not zero");
    a_win_addr: assert property (dat_rd && i_ea[15] ##1 o_prog_rd
        |-> !o_prog_addr[23] && o_prog_addr[14:0] == $past(i_ea[14:0]))
        else $error("window address wrong");
    a_win_tbl_off: assert property (dat_rd && i_tbl_busy |=> !o_prog_rd)
        else $error("window mapped during table access");
    a_low_no_prog: assert property (dat_rd && !i_ea[15] |=> !o_prog_rd)
        else $error("low data address reached program memory");
    a_unimpl_zero: assert property (dat_rd && !i_ea[15] && i_ea > 16'h09FF
        |=> !o_ram_rd ##1 o_rvalid && o_rdata == 16'h0000) else $error("unimplemented read not zero");
    a_mac_x_in_y: assert property (dat_rd && i_mac_op && !i_y_pointer
        && i_ea[15:8] == 8'h09 |-> ##2 o_rvalid && o_rdata == 16'h0000)
        else $error("x pointer reached y space");
endmodule : psda_asserts

bind psda_top psda_asserts psda_asserts_inst (
    .i_clk, .i_nrst, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_req_valid, .i_req_kind,
    .i_req_write, .i_req_byte, .i_req_high, .i_pc, .i_ea, .i_tbl_busy, .i_mac_op,
    .i_y_pointer, .o_prog_addr, .o_prog_rd, .i_prog_rdata, .o_ram_rd, .o_rdata, .o_rvalid
);

`default_nettype wire

// >>> test/psda_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module psda_mem_model (
    // Program memory
    input  wire logic [23:0] i_addr,
    input  wire logic        i_rd,
    output logic      [23:0] o_rdata,
    // Data RAM
    input  wire logic [15:0] i_ram_addr,
    input  wire logic        i_ram_rd,
    output logic      [15:0] o_ram_rdata
);
    // Writes are not stored, so the bench never reads back written data
    always_comb begin
        o_rdata = {i_addr[7:0] ^ 8'h5A, i_addr[23:8] ^ 16'hC3A5};
        o_ram_rdata = {~i_ram_addr[8:1], i_ram_addr[8:1]};
        // Unselected arrays show inverted data so stale values never match
        if (!i_rd) o_rdata = ~o_rdata;
        if (!i_ram_rd) o_ram_rdata = ~o_ram_rdata;
    end
endmodule : psda_mem_model

`default_nettype wire

// >>> test/psda_top_test.sv
`timescale 1ns/1ps
`default_nettype none

module psda_top_test
    import psda_pkg::*;
;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic i_req_valid = 1'b0, i_req_write = 1'b0, i_req_byte = 1'b0, i_req_high = 1'b0;
    logic i_tbl_busy = 1'b0, i_mac_op = 1'b0, i_y_pointer = 1'b0;
    logic i_short_class = 1'b0, i_in_repeat = 1'b0, i_rpt_edge = 1'b0;
    logic [WBA_W-1:0]   i_wb_adr = '0;
    logic [3:0]         i_wb_sel = 4'hF;
    logic [WBD_W-1:0]   i_wb_dat = '0, o_wb_dat, q;
    logic [1:0]         i_req_kind = 2'b00;
    logic [PC_W-1:0]    i_pc = '0;
    logic [EA_W-1:0]    i_ea = '0;
    logic [DW-1:0]      i_wdata = '0, i_ram_rdata, o_rdata, o_ram_addr, rd, o_prog_wdata, o_ram_wdata;
    logic [PADDR_W-1:0] o_prog_addr, i_prog_rdata, ad;
    logic o_wb_ack, o_prog_rd, o_ram_rd, o_rvalid, o_stall, pr, rr, rv, vis_en;
    logic o_prog_wr, o_prog_wr_high, o_ram_wr, o_ram_byte;
    logic [7:0]         tpg, vpg;
    logic [31:0]        seed = 32'h0000_924D, r;
    int                 fails = 0, n_checks = 0, st;

    always #2.5 i_clk = ~i_clk;

    psda_top psda_top_inst (
        .i_clk, .i_nrst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
        .o_wb_dat, .o_wb_ack, .i_req_valid, .i_req_kind, .i_req_write, .i_req_byte,
        .i_req_high, .i_pc, .i_ea, .i_wdata, .i_tbl_busy, .i_mac_op, .i_y_pointer,
        .i_short_class, .i_in_repeat, .i_rpt_edge, .o_prog_addr, .o_prog_rd,
        .o_prog_wr, .o_prog_wr_high, .o_prog_wdata, .i_prog_rdata, .o_ram_addr,
        .o_ram_rd, .o_ram_wr, .o_ram_byte, .o_ram_wdata, .i_ram_rdata, .o_rdata,
        .o_rvalid, .o_stall
    );

    psda_mem_model psda_mem_model_inst (
        .i_addr(o_prog_addr), .i_rd(o_prog_rd), .o_rdata(i_prog_rdata),
        .i_ram_addr(o_ram_addr), .i_ram_rd(o_ram_rd), .o_ram_rdata(i_ram_rdata)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] s = 4'hF);
        @(posedge i_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_sel <= s;
        i_wb_adr <= a;
        i_wb_dat <= {24'h00_0000, d};
        do @(posedge i_clk); while (o_wb_ack !== 1'b1);
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask : wb

    task automatic page(input logic [4:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
        wb(1'b0, a, 8'h00);
        chk(q, {24'h00_0000, d});
    endtask : page

    task automatic rq(input logic [1:0] k, input logic hi, input logic by, input logic [15:0] ea);
        logic [23:0] pa, pw;
        logic [15:0] ed, rw;
        logic win, ram, pe;
        int es;
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req_kind <= k;
        i_req_high <= hi;
        i_req_byte <= by;
        i_ea <= ea;
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        #1;
        ad = o_prog_addr;
        pr = o_prog_rd;
        rr = o_ram_rd;
        rv = 1'b0;
        st = 0;
        repeat (4) begin
            if (o_stall === 1'b1) st++;
            @(posedge i_clk);
            #1;
            if (o_rvalid === 1'b1) rd = o_rdata;
            if (o_rvalid === 1'b1) rv = 1'b1;
        end
        win = k == 2'b10 && ea[15] && vis_en && !i_tbl_busy;
        pe = k == 2'b00 || k == 2'b01 || win;
        pa = k == 2'b00 ? {1'b0, i_pc[22:1], 1'b0} : k == 2'b01 ? {tpg, ea} : {1'b0, vpg, ea[14:0]};
        pw = {pa[7:0] ^ 8'h5A, pa[23:8] ^ 16'hC3A5};
        rw = {~ea[8:1], ea[8:1]};
        ram = k == 2'b10 && ea <= 16'h09FF && (!i_mac_op || i_y_pointer == (ea[15:8] == 8'h09));
        es = !win ? 0 : i_in_repeat ? (i_rpt_edge ? 2 : 1) : (i_short_class ? 1 : 2);
        if (k == 2'b01) begin
            ed = hi ? {8'h00, pw[23:16]} : pw[15:0];
            if (by) ed = hi ? (ea[0] ? 16'h0000 : ed) : {8'h00, ea[0] ? pw[15:8] : pw[7:0]};
        end else begin
            ed = win ? pw[15:0] : ram ? rw : 16'h0000;
            if (by && ram) ed = {8'h00, ea[0] ? rw[15:8] : rw[7:0]};
        end
        chk(pr, pe);
        if (pe) chk(ad, pa);
        chk(rr, ram);
        chk(rv, k == 2'b01 || k == 2'b10);
        if (rv) chk(rd, ed);
        chk(st, es);
    endtask : rq

    // Writes give no result pulse, so their strobes are looked at directly
    task automatic wr(input logic [1:0] k, input logic hi, input logic by, input logic [15:0] ea);
        logic [15:0] d;
        logic        rm;
        r = rnd();
        d = r[15:0];
        rm = k == 2'b10 && ea <= 16'h09FF;
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req_write <= 1'b1;
        i_req_kind <= k;
        i_req_high <= hi;
        i_req_byte <= by;
        i_ea <= ea;
        i_wdata <= d;
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        i_req_write <= 1'b0;
        #1;
        chk(o_prog_wr, k == 2'b01);
        chk(o_ram_wr, rm);
        if (k == 2'b01) chk(o_prog_addr, {tpg, ea});
        if (k == 2'b01) chk({o_prog_wr_high, o_prog_wdata}, {hi, d});
        if (rm) chk({o_ram_wdata, o_ram_addr}, {d, ea});
        if (rm) chk(o_ram_byte, by);
        @(posedge i_clk);
        #1;
        chk(o_rvalid, 1'b0);
    endtask : wr

    initial begin
        repeat (5000) @(posedge i_clk);
        fails++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        for (int a = 0; a < 5'h14; a += 4) begin
            wb(1'b0, a[4:0], 8'h00);
            chk(q, 32'h0000_0000);
        end
        r = rnd();
        vpg = r[15:8];
        page(OFS_VIS_PAGE, vpg);
        page(OFS_CORE_CTL, 8'h01);
        vis_en = 1'b1;
        for (int p = 0; p < 2; p++) begin
            r = rnd();
            tpg = {p[0], r[6:0]};
            page(OFS_TBL_PAGE, tpg);
            for (int i = 0; i < 8; i++) begin
                r = rnd();
                rq(2'b01, i[2], i[1], {r[15:1], i[0]});
            end
        end
        $display("table and page tests done");
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            i_pc <= r[22:0];
            i_short_class <= i[0];
            i_in_repeat <= i[1];
            i_rpt_edge <= i[2];
            rq(2'b00, 1'b0, 1'b0, 16'h0000);
            rq(2'b10, 1'b0, 1'b0, {1'b1, r[30:16]});
        end
        // A table in flight and a disabled window must both leave program memory alone
        i_tbl_busy <= 1'b1;
        rq(2'b10, 1'b0, 1'b0, {1'b1, r[14:0]});
        i_tbl_busy <= 1'b0;
        page(OFS_CORE_CTL, 8'h00);
        vis_en = 1'b0;
        rq(2'b10, 1'b0, 1'b0, {1'b1, r[14:0]});
        rq(2'b11, 1'b0, 1'b0, 16'h0000);
        $display("fetch and window tests done");
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            i_mac_op <= i[0];
            i_y_pointer <= i[1];
            rq(2'b10, 1'b0, r[8], {6'h02, i[3:2], r[7:0]});
        end
        $display("data space tests done");
        // Y pointer left selected: writes still see the composite space
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            wr(2'b01, i[0], 1'b0, r[15:0]);
            wr(2'b10, 1'b0, i[0], {i[1], 4'h0, r[10:0]});
        end
        wr(2'b01, 1'b1, 1'b0, 16'h0ACE);
        wb(1'b0, OFS_LAST_ADR, 8'h00);
        chk(q, {8'h00, tpg, 16'h0ACE});
        // Lane 0 deselected and unmapped offsets must leave the pages alone
        wb(1'b1, OFS_TBL_PAGE, ~tpg, 4'hE);
        wb(1'b1, 5'h10, 8'hFF);
        wb(1'b0, OFS_TBL_PAGE, 8'h00);
        chk(q, {24'h00_0000, tpg});
        wb(1'b0, 5'h10, 8'h00);
        chk(q, 32'h0000_0000);
        $display("write tests done");
        stop_test();
    end
endmodule : psda_top_test

`default_nettype wire
